// File: rtl/spi_mem_pkg.sv
// Constants and types shared by the serial memory command front end.
package spi_mem_pkg;
    localparam logic [7:0]  OPC_SET_LATCH   = 8'h06;
    localparam logic [7:0]  OPC_CLEAR_LATCH = 8'h04;
    localparam logic [7:0]  OPC_STATUS_RD   = 8'h05;
    localparam logic [7:0]  OPC_STATUS_WR   = 8'h01;
    localparam logic [7:0]  OPC_MEM_RD      = 8'h03;
    localparam logic [7:0]  OPC_MEM_WR      = 8'h02;
    localparam int          ADDR_W          = 13;
    localparam logic [12:0] ADDR_LAST       = 13'h1FFF;
    localparam logic [12:0] ADDR_FIRST      = 13'h0000;
    localparam int          LATCH_BIT       = 1;
    localparam logic [7:0]  STATUS_WR_MASK  = 8'h8C;
    localparam logic [7:0]  STATUS_RST      = 8'h00;
    localparam logic [2:0]  BIT_LAST        = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_DATA_IN, ST_DATA_OUT, ST_IGNORE
    } phase_t;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_SET, CMD_CLEAR, CMD_STAT_RD, CMD_STAT_WR, CMD_MEM_RD, CMD_MEM_WR
    } cmd_t;

    function automatic logic [12:0] addr_next(input logic [12:0] a);
        addr_next = (a == ADDR_LAST) ? ADDR_FIRST : a + 13'h0001;
    endfunction
endpackage

// File: rtl/pin_sync.sv
// Two-flop synchroniser for one input from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module pin_sync
    import spi_mem_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = d_i;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= {RST_VAL, RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.sync;
endmodule
`default_nettype wire

// File: rtl/byte_memory.sv
// Byte-wide storage array with one write port and one registered read port.
`timescale 1ns/10ps
`default_nettype none
module byte_memory
    import spi_mem_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [7:0]        wr_data_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [7:0]        rd_data_o
);
    // No reset: the array holds contents, not control state.
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// File: rtl/spi_memory_command_front_end.sv
// Serial memory command front end: framing, command decode, address and latch.
// What this block does
// - Decode 06h as set latch, 04h as clear latch, 05h as status read.
// - Decode 01h as status write, 03h as memory read, 02h as memory write.
// - Read and write take a two-byte address; only low 13 bits are used.
// - Sample input on rising clock edges, change output on falling edges.
// - At select, low clock means mode 0, high clock means mode 3.
// - In mode 3 the first rising edge after toggling starts is bit one.
// - The first byte after select is the opcode; address and data follow.
// - One opcode per select period; master deselects between commands.
// - While deselected, ignore input and keep output in high impedance.
// - All bytes travel most significant bit first in both directions.
// - Unknown opcode: ignore everything until next select, output stays off.
// - Reset clears the write latch so writes are refused until set.
// - Set-latch command sets the latch; status bit shows one when permitted.
// - Status write never changes the latch flag position.
// - Clear latch at deselect ending status-write or memory-write.
// - Clear-latch command clears the latch; status then reads it as zero.
// - One eight-bit status register holds configuration and latch flag.
// - Never report busy; every write completes within its byte.
// - Latch flag is status bit 1; bits 0 and 4 to 6 read zero.
// - After status-read opcode, shift out one status byte.
// - Burst address increments per byte and wraps 1FFFh to 0000h.
`timescale 1ns/10ps
`default_nettype none
module spi_memory_command_front_end
    import spi_mem_pkg::*;
(
    input  wire logic MCLK_I,
    input  wire logic ARST_N_I,
    input  wire logic CS_N_I,
    input  wire logic SCK_I,
    input  wire logic SI_I,
    output logic      SO_O,
    output logic      SO_OE_O,
    output logic      MODE3_O,
    output logic      WRITE_LATCH_FLAG_O,
    output logic      CMD_ERROR_O
);
    typedef struct packed {
        logic              cs_n_d;
        logic              sck_d;
        logic              mode3;
        logic              seen_low;
        phase_t            phase;
        cmd_t              cmd;
        logic [2:0]        bit_cnt;
        logic [7:0]        shreg;
        logic [7:0]        out_sh;
        logic [ADDR_W-1:0] addr;
        logic              latch;
        logic [7:0]        status_cfg;
        logic              clr_at_end;
        logic              load_pend;
        logic              fetch_ok;
        logic              so;
        logic              so_oe;
        logic              cmd_err;
        logic              mem_we;
        logic [ADDR_W-1:0] mem_wa;
        logic [7:0]        mem_wd;
    } fe_state_t;

    fe_state_t st_ff;
    fe_state_t nxt_st;

    logic       cs_n_s;
    logic       sck_s;
    logic       si_s;
    logic [7:0] rd_data;

    // Pins reach logic only through two flops each.
    pin_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .clk_i    (MCLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      (CS_N_I),
        .q_o      (cs_n_s)
    );
    pin_sync #(.RST_VAL(1'b0)) u_sync_sck (
        .clk_i    (MCLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      (SCK_I),
        .q_o      (sck_s)
    );
    pin_sync #(.RST_VAL(1'b0)) u_sync_si (
        .clk_i    (MCLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      (SI_I),
        .q_o      (si_s)
    );

    byte_memory u_mem (
        .clk_i     (MCLK_I),
        .wr_en_i   (st_ff.mem_we),
        .wr_addr_i (st_ff.mem_wa),
        .wr_data_i (st_ff.mem_wd),
        .rd_addr_i (st_ff.addr),
        .rd_data_o (rd_data)
    );

    function automatic cmd_t decode_opcode(input logic [7:0] op);
        unique case (op)
            OPC_SET_LATCH:   decode_opcode = CMD_SET;
            OPC_CLEAR_LATCH: decode_opcode = CMD_CLEAR;
            OPC_STATUS_RD:   decode_opcode = CMD_STAT_RD;
            OPC_STATUS_WR:   decode_opcode = CMD_STAT_WR;
            OPC_MEM_RD:      decode_opcode = CMD_MEM_RD;
            OPC_MEM_WR:      decode_opcode = CMD_MEM_WR;
            default:         decode_opcode = CMD_NONE;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(input logic [7:0] cfg, input logic wl);
        logic [7:0] s;
        s            = cfg & STATUS_WR_MASK;
        s[LATCH_BIT] = wl;
        status_byte  = s;
    endfunction

    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;
    logic       cs_rise;
    logic [7:0] byte_in;
    logic       byte_done;

    always_comb begin
        nxt_st    = st_ff;
        sck_rise  = sck_s && !st_ff.sck_d;
        sck_fall  = !sck_s && st_ff.sck_d;
        cs_fall   = !cs_n_s && st_ff.cs_n_d;
        cs_rise   = cs_n_s && !st_ff.cs_n_d;
        byte_in   = {st_ff.shreg[6:0], si_s};
        byte_done = 1'b0;

        nxt_st.cs_n_d = cs_n_s;
        nxt_st.sck_d  = sck_s;
        nxt_st.mem_we = 1'b0;
        // Marks that the read port has had one clock to follow a new address.
        nxt_st.fetch_ok = st_ff.load_pend;

        if (cs_n_s) begin
            // Deselected: input ignored and output released.
            nxt_st.phase = ST_IDLE;
            nxt_st.so_oe = 1'b0;
            if (cs_rise && st_ff.clr_at_end) begin
                nxt_st.latch = 1'b0;
            end
            nxt_st.clr_at_end = 1'b0;
            nxt_st.load_pend  = 1'b0;
        end else if (cs_fall) begin
            nxt_st.mode3    = sck_s;
            nxt_st.seen_low = !sck_s;
            nxt_st.phase    = ST_OPCODE;
            nxt_st.bit_cnt  = 3'h0;
            nxt_st.cmd      = CMD_NONE;
            nxt_st.cmd_err  = 1'b0;
        end else begin
            if (!sck_s) begin
                nxt_st.seen_low = 1'b1;
            end
            // A rise only counts once the clock has been low in this frame.
            if (sck_rise && st_ff.seen_low && st_ff.phase != ST_IGNORE) begin
                nxt_st.shreg   = byte_in;
                nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                byte_done      = (st_ff.bit_cnt == BIT_LAST);
            end
            if (byte_done) begin
                unique case (st_ff.phase)
                    ST_OPCODE: begin
                        nxt_st.cmd = decode_opcode(byte_in);
                        unique case (decode_opcode(byte_in))
                            CMD_SET: begin
                                nxt_st.latch = 1'b1;
                                nxt_st.phase = ST_IGNORE;
                            end
                            CMD_CLEAR: begin
                                nxt_st.latch = 1'b0;
                                nxt_st.phase = ST_IGNORE;
                            end
                            CMD_STAT_RD: begin
                                nxt_st.out_sh    = status_byte(st_ff.status_cfg, st_ff.latch);
                                nxt_st.load_pend = 1'b0;
                                nxt_st.phase     = ST_DATA_OUT;
                            end
                            CMD_STAT_WR: begin
                                nxt_st.phase      = ST_DATA_IN;
                                nxt_st.clr_at_end = 1'b1;
                            end
                            CMD_MEM_RD, CMD_MEM_WR: begin
                                nxt_st.phase      = ST_ADDR_HI;
                                nxt_st.clr_at_end = (decode_opcode(byte_in) == CMD_MEM_WR);
                            end
                            CMD_NONE: begin
                                nxt_st.phase   = ST_IGNORE;
                                nxt_st.cmd_err = 1'b1;
                            end
                        endcase
                    end
                    ST_ADDR_HI: begin
                        // Three leading bits are dropped.
                        nxt_st.addr[ADDR_W-1:8] = byte_in[ADDR_W-9:0];
                        nxt_st.phase            = ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        nxt_st.addr[7:0] = byte_in;
                        if (st_ff.cmd == CMD_MEM_RD) begin
                            nxt_st.phase     = ST_DATA_OUT;
                            nxt_st.load_pend = 1'b1;
                        end else begin
                            nxt_st.phase = ST_DATA_IN;
                        end
                    end
                    ST_DATA_IN: begin
                        if (st_ff.cmd == CMD_STAT_WR) begin
                            if (st_ff.latch) begin
                                // Latch position is masked out.
                                nxt_st.status_cfg = byte_in & STATUS_WR_MASK;
                            end
                            nxt_st.phase = ST_IGNORE;
                        end else begin
                            // Write lands at once, so no busy state exists.
                            nxt_st.mem_we = st_ff.latch;
                            nxt_st.mem_wa = st_ff.addr;
                            nxt_st.mem_wd = byte_in;
                            nxt_st.addr   = addr_next(st_ff.addr);
                        end
                    end
                    ST_DATA_OUT: begin
                        if (st_ff.cmd == CMD_MEM_RD) begin
                            nxt_st.load_pend = 1'b1;
                        end
                    end
                    ST_IDLE, ST_IGNORE: begin
                    end
                endcase
            end
            // The read port is registered, so its data trails the address by a clock.
            if (st_ff.load_pend && st_ff.fetch_ok && !byte_done && st_ff.phase == ST_DATA_OUT) begin
                nxt_st.out_sh    = rd_data;
                nxt_st.addr      = addr_next(st_ff.addr);
                nxt_st.load_pend = 1'b0;
            end
            if (sck_fall && st_ff.phase == ST_DATA_OUT && st_ff.seen_low) begin
                nxt_st.so     = st_ff.out_sh[7];
                nxt_st.out_sh = {st_ff.out_sh[6:0], 1'b0};
                nxt_st.so_oe  = 1'b1;
            end
            if (st_ff.phase != ST_DATA_OUT) begin
                nxt_st.so_oe = 1'b0;
            end
            // Status read gives one byte and then stops driving.
            if (byte_done && st_ff.phase == ST_DATA_OUT && st_ff.cmd == CMD_STAT_RD) begin
                nxt_st.phase = ST_IGNORE;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_ff            <= '0;
            st_ff.cs_n_d     <= 1'b1;
            st_ff.phase      <= ST_IDLE;
            st_ff.cmd        <= CMD_NONE;
            st_ff.latch      <= 1'b0;
            st_ff.status_cfg <= STATUS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign SO_O               = st_ff.so;
    assign SO_OE_O            = st_ff.so_oe;
    assign MODE3_O            = st_ff.mode3;
    assign WRITE_LATCH_FLAG_O = st_ff.latch;
    assign CMD_ERROR_O        = st_ff.cmd_err;
endmodule
`default_nettype wire

// File: bench/spi_fe_properties.sv
// Concurrent checks on the ports of the serial memory command front end.
`timescale 1ns/10ps
`default_nettype none
module spi_fe_properties (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic CS_N_I,
    input wire logic SCK_I,
    input wire logic SI_I,
    input wire logic SO_O,
    input wire logic SO_OE_O,
    input wire logic MODE3_O,
    input wire logic WRITE_LATCH_FLAG_O,
    input wire logic CMD_ERROR_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    // Six cycles leave room for the two-flop select synchroniser.
    a_oe_off_idle: assert property (CS_N_I [*6] |-> !SO_OE_O)
        else $error("output driven while deselected");
    a_so_steady_high: assert property (
        SCK_I [*4] ##0 (SO_OE_O && $past(SO_OE_O)) |-> $stable(SO_O))
        else $error("output changed while clock high");
    a_mode3_pick: assert property ($fell(CS_N_I) && SCK_I |-> ##[1:8] MODE3_O)
        else $error("mode 3 not detected");
    a_mode0_pick: assert property ($fell(CS_N_I) && !SCK_I |-> ##[1:8] !MODE3_O)
        else $error("mode 0 not detected");
    a_err_cleared: assert property ($fell(CS_N_I) |-> ##[1:8] !CMD_ERROR_O)
        else $error("error flag not cleared at select");
    a_err_quiet: assert property (CMD_ERROR_O |-> !SO_OE_O)
        else $error("output driven after bad opcode");
    a_latch_set_frame: assert property (
        $rose(WRITE_LATCH_FLAG_O) |-> !CS_N_I && !CMD_ERROR_O)
        else $error("latch set outside a valid frame");
    a_latch_hold_idle: assert property (
        CS_N_I [*8] |-> $stable(WRITE_LATCH_FLAG_O))
        else $error("latch moved while long deselected");
    a_oe_in_frame: assert property ($rose(SO_OE_O) |-> !CS_N_I && !CMD_ERROR_O)
        else $error("output enabled outside a read");
endmodule
bind spi_memory_command_front_end spi_fe_properties u_spi_fe_properties (
    .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .CS_N_I(CS_N_I), .SCK_I(SCK_I), .SI_I(SI_I),
    .SO_O(SO_O), .SO_OE_O(SO_OE_O), .MODE3_O(MODE3_O),
    .WRITE_LATCH_FLAG_O(WRITE_LATCH_FLAG_O), .CMD_ERROR_O(CMD_ERROR_O));
`default_nettype wire

// File: bench/spi_master_model.sv
// Behavioural serial bus master that frames commands and collects read bytes.
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
    input  wire logic       mclk_i,
    input  wire logic       so_i,
    input  wire logic       so_oe_i,
    output logic            cs_n_o,
    output logic            sck_o,
    output logic            si_o,
    output logic      [7:0] rx_o,
    output logic            rx_stb_o
);
    logic       idle_lvl;
    logic [7:0] rx;
    // A released output line is pulled high on the board.
    wire        miso = so_oe_i ? so_i : 1'b1;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        rx_o = 8'h00;
        rx_stb_o = 1'b0;
        idle_lvl = 1'b0;
    end
    // Four system cycles per half keeps the link at 320 ns, well under the limit.
    task half();
        repeat (4) @(negedge mclk_i);
    endtask
    task start(input logic m3);
        idle_lvl = m3;
        sck_o = m3;
        half();
        half();
        cs_n_o = 1'b0;
        half();
    endtask
    task xfer(input logic [7:0] tx, input logic chk);
        for (int i = 7; i >= 0; i--) begin
            if (idle_lvl) sck_o = 1'b0;
            si_o = tx[i];
            half();
            sck_o = 1'b1;
            repeat (3) @(negedge mclk_i);
            rx[i] = miso;
            @(negedge mclk_i);
            if (!idle_lvl) sck_o = 1'b0;
        end
        if (chk) begin
            rx_o = rx;
            rx_stb_o = 1'b1;
            @(negedge mclk_i);
            rx_stb_o = 1'b0;
        end
    endtask
    // Input noise while deselected must be ignored by the device.
    task stop();
        half();
        cs_n_o = 1'b1;
        repeat (10) begin
            @(negedge mclk_i);
            si_o = ~si_o;
        end
    endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the serial memory command front end.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import spi_mem_pkg::*;
;
    logic       mclk;
    logic       arst_n;
    wire        cs_n, sck, si, so, so_oe, mode3, latch, cmd_err, rx_stb;
    wire  [7:0] rx;
    logic [7:0] exp_q[$];
    logic [7:0] bad[3] = '{8'h00, 8'hFF, 8'h86};
    logic [7:0] stat;
    logic [7:0] rnd;
    logic       m3;
    int         n_fail;
    int         comparisons;

    spi_memory_command_front_end u_spi_memory_command_front_end (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si),
        .SO_O(so), .SO_OE_O(so_oe), .MODE3_O(mode3), .WRITE_LATCH_FLAG_O(latch),
        .CMD_ERROR_O(cmd_err));
    spi_master_model u_spi_master_model (
        .mclk_i(mclk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck),
        .si_o(si), .rx_o(rx), .rx_stb_o(rx_stb));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic complete_run();
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("MISMATCH t=%0t %0d expected bytes never read", $time, exp_q.size());
        end
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One select period: opcode, up to four sent bytes, then read bytes.
    task automatic frame(input logic [7:0] op, input logic [31:0] tx, input int ntx,
                         input int nrd);
        u_spi_master_model.start(m3);
        u_spi_master_model.xfer(op, 1'b0);
        for (int i = 0; i < ntx; i++) u_spi_master_model.xfer(tx[31-8*i -: 8], 1'b0);
        repeat (nrd) u_spi_master_model.xfer(8'h00, 1'b1);
        u_spi_master_model.stop();
    endtask
    always @(posedge mclk) begin
        if (rx_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                comparisons++;
                n_fail++;
                $display("MISMATCH t=%0t unexpected byte %h", $time, rx);
            end else begin
                check(rx, exp_q.pop_front(), "read byte");
            end
        end
    end
    initial begin
        #3_000_000;
        n_fail++;
        complete_run();
    end
    initial begin
        arst_n = 1'b0;
        n_fail = 0;
        comparisons = 0;
        m3 = 1'b0;
        rnd = 8'($urandom(32'hC32A));
        repeat (12) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check({7'h00, latch}, 8'h00, "latch after reset");
        exp_q.push_back(STATUS_RST);
        frame(OPC_STATUS_RD, 32'h0, 0, 1);
        for (int k = 0; k < 4; k++) begin
            m3 = k[0];
            frame(OPC_SET_LATCH, 32'h0, 0, 0);
            check({7'h00, latch}, 8'h01, "latch set");
            check({7'h00, mode3}, {7'h00, m3}, "mode");
            check({7'h00, cmd_err}, 8'h00, "error flag after good opcode");
            rnd = 8'($urandom);
            stat = rnd & STATUS_WR_MASK;
            frame(OPC_STATUS_WR, {rnd | 8'h02, 24'h0}, 1, 0);
            check({7'h00, latch}, 8'h00, "latch after status write");
            exp_q.push_back(stat);
            frame(OPC_STATUS_RD, 32'h0, 0, 1);
            frame(OPC_SET_LATCH, 32'h0, 0, 0);
            exp_q.push_back(stat | 8'h02);
            frame(OPC_STATUS_RD, 32'h0, 0, 1);
            frame(OPC_CLEAR_LATCH, 32'h0, 0, 0);
            check({7'h00, latch}, 8'h00, "latch clear");
            frame(OPC_STATUS_WR, {~rnd, 24'h0}, 1, 0);
            exp_q.push_back(stat);
            frame(OPC_STATUS_RD, 32'h0, 0, 1);
        end
        m3 = 1'b0;
        frame(OPC_SET_LATCH, 32'h0, 0, 0);
        frame(OPC_STATUS_WR, 32'h0, 1, 0);
        frame(OPC_SET_LATCH, 32'h0, 0, 0);
        frame(OPC_MEM_WR, {rnd[7:5], 13'h1FFF, rnd, ~rnd}, 4, 0);
        check({7'h00, latch}, 8'h00, "latch after memory write");
        frame(OPC_MEM_WR, {16'h1FFF, 16'h5AA5}, 4, 0);
        exp_q.push_back(rnd);
        exp_q.push_back(~rnd);
        m3 = 1'b1;
        frame(OPC_MEM_RD, {16'h1FFF, 16'h0}, 2, 2);
        // A set latch must survive unknown opcodes untouched.
        frame(OPC_SET_LATCH, 32'h0, 0, 0);
        foreach (bad[j]) begin
            exp_q.push_back(8'hFF);
            frame(bad[j], 32'h0, 0, 1);
            check({7'h00, cmd_err}, 8'h01, "bad opcode flag");
            check({7'h00, latch}, 8'h01, "latch after bad opcode");
        end
        complete_run();
    end
endmodule
`default_nettype wire
